// file: pkg/adc_cal_defs.svh
/*
  named constants for the calibration control block: register offsets, reset values,
  field positions and timing counts. assumes a 100 MHz mclk and an 8-bit register port.
*/
// Summary of operation
// - writing trigger bit 3 starts foreground calibration
// - trigger bit self-clears, always reads zero
// - trigger resets calibration state machine first
// - bit 4 opens vector port at 0x05a
// - range field bits 6-4, reset 111
// - only run bit safe during background calibration
// - run bit starts, clearing pauses background calibration
// - bit 0 enables background mode, resets zero
// - clearing mode bit may leave calibration incomplete
// - stopped flag zero while running, delayed stop
// - completion flag shows first calibration finished
// - successive vector accesses step through all values
// - timing calibration runs on trigger when enabled
`ifndef ADC_CAL_DEFS_SVH
`define ADC_CAL_DEFS_SVH

`define CAL_ADDR_W    12
`define CAL_DATA_W    8
`define CAL_VEC_DEPTH 16
`define CAL_PTR_W     4
`define CAL_CNT_W     8

`define CALIBRATION_CONFIG_0_OFS  12'h050
`define CALIBRATION_CONFIG_1_OFS  12'h051
`define CAL_BACK_OFS  12'h057
`define CAL_PAT_OFS   12'h058
`define CAL_VEC_OFS   12'h05a
`define CAL_STAT_OFS  12'h05b
`define CAL_TCAL_OFS  12'h066

`define CALIBRATION_CONFIG_0_RST  8'h06
`define CALIBRATION_CONFIG_1_RST  8'hf4
`define CAL_BACK_RST  8'h10
`define CAL_PAT_RST   8'h00
`define CAL_TCAL_RST  8'h02
`define CAL_VEC_RST   8'h00
`define CAL_STAT_RSVD 8'h08
`define CAL_ZERO_BYTE 8'h00

`define CAL_TRIG_BIT  3
`define CAL_VEN_BIT   4
`define CAL_RANGE_HI  6
`define CAL_RANGE_LO  4
`define CAL_RUN_BIT   1
`define CAL_MODE_BIT  0
`define CAL_TAUTO_BIT 0
`define CAL_STOP_BIT  1
`define CAL_DONE_BIT  0
`define CAL_RANGE_RST 3'h7

`define CAL_CLK_NS    10
`define CAL_FG_NS     2000
`define CAL_TIM_NS    500
`define CAL_STOP_NS   100
`define CAL_FG_CYC    ((`CAL_FG_NS + `CAL_CLK_NS - 1) / `CAL_CLK_NS)
`define CAL_TIM_CYC   ((`CAL_TIM_NS + `CAL_CLK_NS - 1) / `CAL_CLK_NS)
`define CAL_STOP_CYC  ((`CAL_STOP_NS + `CAL_CLK_NS - 1) / `CAL_CLK_NS)

`endif

// file: pkg/adc_cal_pkg.sv
/*
  types shared by the calibration control block and its vector memory.
  assumes adc_cal_defs.svh is on the include path.
*/
`include "adc_cal_defs.svh"
package adc_cal_pkg;

  typedef enum logic [2:0] {
    cal_idle,
    cal_init,
    cal_timing,
    cal_fg,
    cal_bg,
    cal_bg_stop
  } cal_state_t;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`CAL_ADDR_W-1:0] addr;
    logic [`CAL_DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [`CAL_DATA_W-1:0] cfg0;
    logic [`CAL_DATA_W-1:0] cfg1;
    logic [`CAL_DATA_W-1:0] back;
    logic [`CAL_DATA_W-1:0] pat;
    logic [`CAL_DATA_W-1:0] tcal;
    logic [`CAL_DATA_W-1:0] rd_data;
    logic                   rd_valid;
    logic [`CAL_PTR_W-1:0]  ptr;
    cal_state_t             cal;
    logic [`CAL_CNT_W-1:0]  cnt;
    logic                   first_done;
    logic                   stopped;
    logic                   complete;
  } ctl_state_t;

  typedef struct packed {
    logic [`CAL_VEC_DEPTH-1:0][`CAL_DATA_W-1:0] mem;
    logic [`CAL_DATA_W-1:0]                     rdata;
  } vec_state_t;

endpackage : adc_cal_pkg

// file: design/calibration_vector_port_mem.sv
/*
  calibration vector store: one write port, one read port with registered read data.
  assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_defs.svh"
module calibration_vector_port_mem
  import adc_cal_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire logic                   we,
  input  wire logic [`CAL_PTR_W-1:0]  waddr,
  input  wire logic [`CAL_DATA_W-1:0] wdata,
  input  wire logic [`CAL_PTR_W-1:0]  raddr,
  output logic      [`CAL_DATA_W-1:0] rdata
);
  vec_state_t st_reg;
  vec_state_t st_next;

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < `CAL_VEC_DEPTH; i++) begin
      if (we && (waddr == `CAL_PTR_W'(i))) begin
        st_next.mem[i] = wdata;
      end
    end
    st_next.rdata = st_next.mem[raddr];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
endmodule : calibration_vector_port_mem
`default_nettype wire

// file: design/adc_calibration_control.sv
/*
  calibration control register bank with a compact calibration sequencer.
  assumes register requests are synchronous to mclk, one request per cycle;
  analog calibration itself and the serial link live elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_defs.svh"
module adc_calibration_control
  import adc_cal_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire reg_req_t               reg_req,
  output logic      [`CAL_DATA_W-1:0] rd_data,
  output logic                        rd_valid,
  output logic                        cal_running,
  output logic                        timing_cal_active,
  output logic      [2:0]             signal_range_select,
  output logic                        cal_complete
);
  ctl_state_t             st_reg;
  ctl_state_t             st_next;
  logic                   foreground_trigger;
  logic                   vec_rd;
  logic                   vec_wr;
  logic                   vec_en;
  logic                   background_run;
  logic                   background_mode_enable;
  logic                   t_auto;
  logic [`CAL_PTR_W-1:0]  mem_raddr;
  logic [`CAL_DATA_W-1:0] mem_rdata;

  // settings read straight from register bank, no crossing
  assign vec_en                 = st_reg.cfg0[`CAL_VEN_BIT];
  assign background_run         = st_reg.back[`CAL_RUN_BIT];
  assign background_mode_enable = st_reg.back[`CAL_MODE_BIT];
  assign t_auto                 = st_reg.tcal[`CAL_TAUTO_BIT];

  always_comb begin
    st_next            = st_reg;
    st_next.rd_valid   = 1'b0;
    foreground_trigger = 1'b0;
    vec_rd             = 1'b0;
    vec_wr             = 1'b0;

    // register writes; accepted at any time, even mid-calibration
    if (reg_req.wr) begin
      if (reg_req.addr == `CALIBRATION_CONFIG_0_OFS) begin
        st_next.cfg0                = reg_req.wdata;
        st_next.cfg0[`CAL_TRIG_BIT] = 1'b0;
        foreground_trigger          = reg_req.wdata[`CAL_TRIG_BIT];
      end else if (reg_req.addr == `CALIBRATION_CONFIG_1_OFS) begin
        st_next.cfg1 = reg_req.wdata;
      end else if (reg_req.addr == `CAL_BACK_OFS) begin
        st_next.back = reg_req.wdata;
      end else if (reg_req.addr == `CAL_PAT_OFS) begin
        st_next.pat = reg_req.wdata;
      end else if (reg_req.addr == `CAL_TCAL_OFS) begin
        st_next.tcal = reg_req.wdata;
      end else if (reg_req.addr == `CAL_VEC_OFS) begin
        vec_wr = vec_en;
      end
    end

    // register reads, answered one cycle later
    if (reg_req.rd) begin
      st_next.rd_valid = 1'b1;
      if (reg_req.addr == `CALIBRATION_CONFIG_0_OFS) begin
        st_next.rd_data = st_reg.cfg0;
      end else if (reg_req.addr == `CALIBRATION_CONFIG_1_OFS) begin
        st_next.rd_data = st_reg.cfg1;
      end else if (reg_req.addr == `CAL_BACK_OFS) begin
        st_next.rd_data = st_reg.back;
      end else if (reg_req.addr == `CAL_PAT_OFS) begin
        st_next.rd_data = st_reg.pat;
      end else if (reg_req.addr == `CAL_TCAL_OFS) begin
        st_next.rd_data = st_reg.tcal;
      end else if (reg_req.addr == `CAL_VEC_OFS) begin
        st_next.rd_data = vec_en ? mem_rdata : `CAL_ZERO_BYTE;
        vec_rd          = vec_en;
      end else if (reg_req.addr == `CAL_STAT_OFS) begin
        st_next.rd_data                = `CAL_STAT_RSVD;
        st_next.rd_data[`CAL_STOP_BIT] = st_reg.stopped;
        st_next.rd_data[`CAL_DONE_BIT] = st_reg.first_done;
      end else begin
        st_next.rd_data = `CAL_ZERO_BYTE;
      end
    end

    // vector pointer steps once per access, rewinds while port closed
    if (!vec_en) begin
      st_next.ptr = '0;
    end else if (vec_rd || vec_wr) begin
      st_next.ptr = st_reg.ptr + `CAL_PTR_W'(1);
    end

    // calibration sequencer
    st_next.cnt = st_reg.cnt + `CAL_CNT_W'(1);
    case (st_reg.cal)
      cal_idle: begin
        st_next.cnt = '0;
        if (background_mode_enable && background_run) begin
          st_next.cal = cal_bg;
        end
      end
      cal_init: begin
        st_next.cnt = '0;
        st_next.cal = t_auto ? cal_timing : cal_fg;
      end
      cal_timing: begin
        if (st_reg.cnt == `CAL_CNT_W'(`CAL_TIM_CYC - 1)) begin
          st_next.cnt = '0;
          st_next.cal = cal_fg;
        end
      end
      cal_fg: begin
        if (st_reg.cnt == `CAL_CNT_W'(`CAL_FG_CYC - 1)) begin
          st_next.cnt        = '0;
          st_next.first_done = 1'b1;
          st_next.complete   = 1'b1;
          st_next.cal        = cal_idle;
        end
      end
      cal_bg: begin
        if (!background_mode_enable) begin
          st_next.complete = 1'b0;
          st_next.cal      = cal_idle;
        end else if (!background_run) begin
          st_next.cnt = '0;
          st_next.cal = cal_bg_stop;
        end
      end
      cal_bg_stop: begin
        if (!background_mode_enable) begin
          st_next.complete = 1'b0;
          st_next.cal      = cal_idle;
        end else if (background_run) begin
          st_next.cal = cal_bg;
        end else if (st_reg.cnt == `CAL_CNT_W'(`CAL_STOP_CYC - 1)) begin
          st_next.cal = cal_idle;
        end
      end
      default: begin
        st_next.cal = cal_idle;
      end
    endcase

    // trigger overrides any running sequence and restarts from the top
    if (foreground_trigger) begin
      st_next.cal = cal_init;
      st_next.cnt = '0;
    end

    st_next.stopped = (st_next.cal == cal_idle);
    mem_raddr       = st_next.ptr;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '{cfg0: `CALIBRATION_CONFIG_0_RST, cfg1: `CALIBRATION_CONFIG_1_RST, back: `CAL_BACK_RST,
                  pat: `CAL_PAT_RST, tcal: `CAL_TCAL_RST, rd_data: `CAL_VEC_RST,
                  rd_valid: 1'b0, ptr: '0, cal: cal_idle, cnt: '0,
                  first_done: 1'b0, stopped: 1'b1, complete: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  calibration_vector_port_mem i_calibration_vector_port_mem (
    .mclk  (mclk),
    .srst  (srst),
    .we    (vec_wr),
    .waddr (st_reg.ptr),
    .wdata (reg_req.wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  assign rd_data             = st_reg.rd_data;
  assign rd_valid            = st_reg.rd_valid;
  assign cal_running         = !st_reg.stopped;
  assign timing_cal_active   = (st_reg.cal == cal_timing);
  assign signal_range_select = st_reg.cfg1[`CAL_RANGE_HI:`CAL_RANGE_LO];
  assign cal_complete        = st_reg.complete;

  logic trig_wr;
  assign trig_wr = reg_req.wr && (reg_req.addr == `CALIBRATION_CONFIG_0_OFS) && reg_req.wdata[`CAL_TRIG_BIT];

  a_trigger_restart: assert property (@(posedge mclk) disable iff (srst)
    trig_wr |=> (st_reg.cal == cal_init) ##1 (st_reg.cal inside {cal_timing, cal_fg}))
    else $error("trigger did not restart the sequencer");

  a_trigger_selfclear: assert property (@(posedge mclk) disable iff (srst)
    trig_wr |=> (st_reg.cfg0[`CAL_TRIG_BIT] == 1'b0) && cal_running)
    else $error("trigger bit did not clear itself");

  a_fg_run_length: assert property (@(posedge mclk) disable iff (srst)
    (trig_wr && !t_auto) ##1 (!trig_wr) [*3] |-> (st_reg.cal == cal_fg) && cal_running)
    else $error("foreground run not in progress after trigger");

  a_vector_step: assert property (@(posedge mclk) disable iff (srst)
    (reg_req.rd && reg_req.addr == `CAL_VEC_OFS && vec_en && !reg_req.wr)
      |=> st_reg.ptr == $past(st_reg.ptr) + `CAL_PTR_W'(1))
    else $error("vector pointer did not advance");

  a_vector_closed: assert property (@(posedge mclk) disable iff (srst)
    (reg_req.rd && reg_req.addr == `CAL_VEC_OFS && !vec_en) |=> rd_valid && rd_data == `CAL_ZERO_BYTE)
    else $error("vector port answered while closed");

  a_range_reset: assert property (@(posedge mclk)
    $past(srst) |-> signal_range_select == `CAL_RANGE_RST)
    else $error("signal range not at reset value");

  a_bg_start: assert property (@(posedge mclk) disable iff (srst)
    (st_reg.cal == cal_idle && background_mode_enable && background_run && !trig_wr)
      |=> st_reg.cal == cal_bg ##1 cal_running)
    else $error("background calibration did not start");

  a_stop_delayed: assert property (@(posedge mclk) disable iff (srst)
    (st_reg.cal == cal_bg && background_mode_enable && !background_run && !trig_wr)
      |=> (st_reg.cal == cal_bg_stop) && cal_running)
    else $error("background stop was not delayed");

  a_done_flag: assert property (@(posedge mclk) disable iff (srst)
    (st_reg.cal == cal_fg && st_reg.cnt == `CAL_CNT_W'(`CAL_FG_CYC - 1) && !trig_wr)
      |=> st_reg.first_done && cal_complete && !cal_running)
    else $error("completion flag not set at end of run");

  a_timing_first: assert property (@(posedge mclk) disable iff (srst)
    (st_reg.cal == cal_init && t_auto && !trig_wr) |=> timing_cal_active)
    else $error("timing calibration skipped");

  a_bg_abandon: assert property (@(posedge mclk) disable iff (srst)
    (st_reg.cal == cal_bg && !background_mode_enable && !trig_wr) |=> !cal_complete && !cal_running)
    else $error("abandoned background left complete");

  a_mode_reset: assert property (@(posedge mclk)
    $past(srst) |-> !background_mode_enable && !cal_running)
    else $error("background mode not clear after reset");

  a_trigger_reads_zero: assert property (@(posedge mclk) disable iff (srst)
    (reg_req.rd && reg_req.addr == `CALIBRATION_CONFIG_0_OFS)
      |=> rd_valid && !rd_data[`CAL_TRIG_BIT])
    else $error("trigger bit read back as one");

  a_stat_running: assert property (@(posedge mclk) disable iff (srst)
    (reg_req.rd && reg_req.addr == `CAL_STAT_OFS && cal_running)
      |=> rd_valid && !rd_data[`CAL_STOP_BIT])
    else $error("stopped flag set while calibration runs");

  a_stat_done: assert property (@(posedge mclk) disable iff (srst)
    (reg_req.rd && reg_req.addr == `CAL_STAT_OFS && cal_complete)
      |=> rd_valid && rd_data[`CAL_DONE_BIT])
    else $error("completion flag missing from status");

  a_done_sticky: assert property (@(posedge mclk) disable iff (srst)
    st_reg.first_done
      |=> st_reg.first_done)
    else $error("completion flag dropped without reset");

  a_range_follow: assert property (@(posedge mclk) disable iff (srst)
    (reg_req.wr && reg_req.addr == `CALIBRATION_CONFIG_1_OFS)
      |=> signal_range_select == $past(reg_req.wdata[`CAL_RANGE_HI:`CAL_RANGE_LO]))
    else $error("signal range did not follow the write");

  a_mode_follow: assert property (@(posedge mclk) disable iff (srst)
    (reg_req.wr && reg_req.addr == `CAL_BACK_OFS)
      |=> background_mode_enable == $past(reg_req.wdata[`CAL_MODE_BIT]))
    else $error("background mode bit did not follow the write");

  a_run_follow: assert property (@(posedge mclk) disable iff (srst)
    (reg_req.wr && reg_req.addr == `CAL_BACK_OFS)
      |=> background_run == $past(reg_req.wdata[`CAL_RUN_BIT]))
    else $error("run bit did not follow the write");

  a_vector_wr_step: assert property (@(posedge mclk) disable iff (srst)
    (reg_req.wr && reg_req.addr == `CAL_VEC_OFS && vec_en && !reg_req.rd)
      |=> st_reg.ptr == $past(st_reg.ptr) + `CAL_PTR_W'(1))
    else $error("vector pointer did not advance on write");

  a_vector_rewind: assert property (@(posedge mclk) disable iff (srst)
    !vec_en
      |=> st_reg.ptr == '0)
    else $error("vector pointer not rewound while port closed");

  a_bg_resume: assert property (@(posedge mclk) disable iff (srst)
    (st_reg.cal == cal_bg_stop && background_mode_enable && background_run && !trig_wr)
      |=> (st_reg.cal == cal_bg) && cal_running)
    else $error("background calibration did not resume");

  a_stop_latency: assert property (@(posedge mclk) disable iff (srst)
    (st_reg.cal == cal_bg_stop && background_mode_enable && !background_run && !trig_wr
       && st_reg.cnt == `CAL_CNT_W'(`CAL_STOP_CYC - 1))
      |=> (st_reg.cal == cal_idle) && !cal_running)
    else $error("background stop did not finish");

  a_timing_length: assert property (@(posedge mclk) disable iff (srst)
    (st_reg.cal == cal_timing && st_reg.cnt == `CAL_CNT_W'(`CAL_TIM_CYC - 1) && !trig_wr)
      |=> (st_reg.cal == cal_fg) && !timing_cal_active)
    else $error("timing phase did not hand over to foreground run");

  a_idle_needs_mode: assert property (@(posedge mclk) disable iff (srst)
    (st_reg.cal == cal_idle && !background_mode_enable && !trig_wr)
      |=> (st_reg.cal == cal_idle) && !cal_running)
    else $error("calibration started without background mode");
endmodule : adc_calibration_control
`default_nettype wire

// file: verification/test_adc_calibration_control.sv
/*
  self-checking testbench for adc_calibration_control: register reset values,
  read/write access, foreground trigger, timing phase, vector port and background control.
  assumes adc_cal_defs.svh on the include path and adc_cal_pkg compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_defs.svh"
module test_adc_calibration_control;
  import adc_cal_pkg::*;

  logic       mclk;
  logic       srst;
  reg_req_t   reg_req;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       cal_running;
  logic       timing_cal_active;
  logic [2:0] signal_range_select;
  logic       cal_complete;
  int         bad_count;
  int         comparisons;
  int         n;

  adc_calibration_control i_adc_calibration_control (
    .mclk                (mclk),
    .srst                (srst),
    .reg_req             (reg_req),
    .rd_data             (rd_data),
    .rd_valid            (rd_valid),
    .cal_running         (cal_running),
    .timing_cal_active   (timing_cal_active),
    .signal_range_select (signal_range_select),
    .cal_complete        (cal_complete)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] val, input logic [7:0] exp);
    comparisons++;
    if (val !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, val, exp);
    end
  endtask : chk

  // in-range check for a cycle count
  task automatic chk_span(input int val, input int lo, input int hi);
    chk({7'h00, (val >= lo && val <= hi)}, 8'h01);
  endtask : chk_span

  task automatic wr_reg(input logic [11:0] addr, input logic [7:0] data);
    @(posedge mclk);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge mclk);
    #1;
    reg_req = '0;
  endtask : wr_reg

  // answer is registered: valid one cycle after the request edge
  task automatic rd_chk(input logic [11:0] addr, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge mclk);
    #1;
    reg_req = '0;
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, exp);
  endtask : rd_chk

  task automatic wait_run(input logic lvl, output int cnt);
    cnt = 0;
    while (cal_running !== lvl && cnt < 1000) begin
      @(posedge mclk);
      #1;
      cnt++;
    end
  endtask : wait_run

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  initial begin
    srst = 1'b1;
    reg_req = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk);
    #1;
    srst = 1'b0;
    // reset values and unmapped place
    rd_chk(12'h050, 8'h06);
    rd_chk(12'h051, 8'hf4);
    rd_chk(12'h057, 8'h10);
    rd_chk(12'h058, 8'h00);
    rd_chk(12'h066, 8'h02);
    rd_chk(12'h05a, 8'h00);
    rd_chk(12'h05b, 8'h0a);
    rd_chk(12'h052, 8'h00);
    chk({5'h00, signal_range_select}, 8'h07);
    chk({6'h00, cal_complete, cal_running}, 8'h00);
    // settings first, trigger last
    wr_reg(12'h051, 8'h84);
    chk({5'h00, signal_range_select}, 8'h00);
    rd_chk(12'h051, 8'h84);
    wr_reg(12'h058, 8'h06);
    rd_chk(12'h058, 8'h06);
    wr_reg(12'h052, 8'hff);
    rd_chk(12'h052, 8'h00);
    // foreground run, restarted in mid-run
    wr_reg(12'h050, 8'h0e);
    wait_run(1'b1, n);
    chk_span(n, 0, 2);
    rd_chk(12'h050, 8'h06);
    rd_chk(12'h05b, 8'h08);
    repeat (100) @(posedge mclk);
    #1;
    wr_reg(12'h050, 8'h0e);
    wait_run(1'b0, n);
    chk_span(n, 195, 210);
    chk({7'h00, cal_complete}, 8'h01);
    rd_chk(12'h05b, 8'h0b);
    // timing phase ahead of the foreground run
    wr_reg(12'h066, 8'h03);
    wr_reg(12'h050, 8'h0e);
    n = 0;
    while (timing_cal_active !== 1'b1 && n < 5) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk_span(n, 0, 2);
    n = 0;
    while (timing_cal_active === 1'b1 && n < 1000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk_span(n, 48, 52);
    wait_run(1'b0, n);
    chk_span(n, 195, 210);
    wr_reg(12'h066, 8'h02);
    // vector port closed, then filled, rewound and read with wrap
    wr_reg(12'h05a, 8'h55);
    rd_chk(12'h05a, 8'h00);
    wr_reg(12'h050, 8'h16);
    rd_chk(12'h050, 8'h16);
    for (int i = 0; i < 16; i++) begin
      wr_reg(12'h05a, 8'(i * 17 + 3));
    end
    wr_reg(12'h050, 8'h06);
    wr_reg(12'h050, 8'h16);
    for (int i = 0; i < 17; i++) begin
      rd_chk(12'h05a, 8'((i % 16) * 17 + 3));
    end
    wr_reg(12'h050, 8'h06);
    // background start, pause, resume, abandon
    wr_reg(12'h057, 8'h13);
    wait_run(1'b1, n);
    chk_span(n, 0, 3);
    rd_chk(12'h05b, 8'h09);
    wr_reg(12'h057, 8'h11);
    chk({7'h00, cal_running}, 8'h01);
    wait_run(1'b0, n);
    chk_span(n, 5, 12);
    rd_chk(12'h05b, 8'h0b);
    rd_chk(12'h057, 8'h11);
    wr_reg(12'h057, 8'h13);
    wait_run(1'b1, n);
    chk_span(n, 0, 3);
    wr_reg(12'h057, 8'h11);
    wr_reg(12'h057, 8'h13);
    repeat (15) @(posedge mclk);
    #1;
    chk({7'h00, cal_running}, 8'h01);
    wr_reg(12'h057, 8'h10);
    wait_run(1'b0, n);
    chk_span(n, 0, 2);
    chk({7'h00, cal_complete}, 8'h00);
    wr_reg(12'h050, 8'h0e);
    wait_run(1'b1, n);
    wait_run(1'b0, n);
    chk({7'h00, cal_complete}, 8'h01);
    // reset in mid-run returns signal range, flags, status and config 1 to their reset values
    wr_reg(12'h050, 8'h0e);
    repeat (20) @(posedge mclk);
    #1;
    srst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    srst = 1'b0;
    chk({5'h00, signal_range_select}, 8'h07);
    chk({6'h00, cal_complete, cal_running}, 8'h00);
    rd_chk(12'h05b, 8'h0a);
    rd_chk(12'h051, 8'hf4);
    complete_run();
  end
endmodule : test_adc_calibration_control
`default_nettype wire
